/* File: hbs_pkg.sv */
package hbs_pkg;
   // Register byte offsets
   localparam logic [5:0] OFS_CTRL      = 6'h00;
   localparam logic [5:0] OFS_RATE      = 6'h04;
   localparam logic [5:0] OFS_CAL_LEN   = 6'h08;
   localparam logic [5:0] OFS_SKEW_LEN  = 6'h0C;
   localparam logic [5:0] OFS_PRE_STEPS = 6'h10;
   localparam logic [5:0] OFS_IDL_TRAIL = 6'h14;
   localparam logic [5:0] OFS_IDL_ZERO  = 6'h18;
   localparam logic [5:0] OFS_IDL_LEAD  = 6'h1C;
   localparam logic [5:0] OFS_PAY_LEN   = 6'h20;
   localparam logic [5:0] OFS_PAY_WORD  = 6'h24;
   localparam logic [5:0] OFS_STATUS    = 6'h28;
   // Control bit positions
   localparam int CTRL_GO_CAL   = 0;
   localparam int CTRL_RUN_IDLE = 1;
   localparam int CTRL_CAL_LOW  = 2;
   localparam int CTRL_PRE_EN   = 3;
   // Rate threshold in Mbit/s and payload ceiling in microseconds
   localparam logic [15:0] RATE_THRESH_MBPS = 16'h09C4;
   localparam logic [7:0]  CAL_MAX_US       = 8'h64;
   // Reset values; rate in Mbit/s, lengths in UI or steps
   localparam logic [15:0] RST_RATE      = 16'h03E8;
   localparam logic [23:0] RST_CAL_LEN   = 24'h00_1000;
   localparam logic [23:0] RST_SKEW_LEN  = 24'h00_0400;
   localparam logic [4:0]  RST_PRE_STEPS = 5'h01;
   localparam logic [4:0]  MAX_PRE_STEPS = 5'h10;
   localparam logic [23:0] RST_IDL_TRAIL = 24'h00_0040;
   localparam logic [23:0] RST_IDL_ZERO  = 24'h00_0040;
   localparam logic [23:0] RST_IDL_LEAD  = 24'h00_0040;
   localparam logic [23:0] RST_PAY_LEN   = 24'h00_0100;
   localparam logic [7:0]  RST_PAY_WORD  = 8'hA5;
   // Fixed sequence lengths in UI or stop-state repetitions
   localparam logic [23:0] LEN_STOP_LONG = 24'h00_0080;
   localparam logic [23:0] LEN_STOP_PRE  = 24'h00_0010;
   localparam logic [23:0] LEN_STOP_ONE  = 24'h00_0001;
   localparam logic [23:0] LEN_ENTRY     = 24'h00_0002;
   localparam logic [23:0] LEN_HS0       = 24'h00_0008;
   localparam logic [23:0] LEN_BYTE      = 24'h00_0008;
   localparam logic [23:0] LEN_PRE_STEP  = 24'h00_0020;
   // Fixed line patterns; the two words sent from the left-hand bit, the PRBS seed from the low bit
   localparam logic [7:0] ALT_SYNC_WORD = 8'hF0;
   localparam logic [7:0] LEADER_WORD   = 8'h1D;
   localparam logic [8:0] PRBS_SEED     = 9'h1FF;
   // Lane states: stop, LP-10, LP-00
   localparam logic [1:0] LP_STOP = 2'h3;
   localparam logic [1:0] LP_10   = 2'h2;
   localparam logic [1:0] LP_00   = 2'h0;

   typedef enum logic [4:0] {
      ST_IDLE      = 5'b00000, ST_INIT     = 5'b00001, ST_PRECAL    = 5'b00010,
      ST_CAL_ENTRY = 5'b00011, ST_SKEW     = 5'b00100, ST_ALT_HS0   = 5'b00101,
      ST_ALT_SYNC  = 5'b00110, ST_ALT_PRBS = 5'b00111, ST_POSTCAL   = 5'b01000,
      ST_B_STOP    = 5'b01001, ST_B_ENTRY  = 5'b01010, ST_B_HS0     = 5'b01011,
      ST_B_PRE     = 5'b01100, ST_B_EXT    = 5'b01101, ST_B_LEAD    = 5'b01110,
      ST_B_DATA    = 5'b01111, ST_I_TRAIL  = 5'b10000, ST_I_ZERO    = 5'b10001,
      ST_I_LEAD    = 5'b10010, ST_B_END    = 5'b10011
   } hbs_state_e;
endpackage : hbs_pkg

/* File: hbs_prbs_if.sv */
`timescale 1ns/100ps
// Links the sequencer to the pseudo-random source
interface hbs_prbs_if;
   logic init;
   logic step;
   logic bit_out;
   modport seq  (output init, output step, input bit_out);
   modport prbs (input init, input step, output bit_out);
endinterface : hbs_prbs_if

/* File: hbs_prbs9.sv */
`timescale 1ns/100ps
module hbs_prbs9
   import hbs_pkg::*;
(
   input wire logic   ref_clk_i,
   input wire logic   rst_i,
   hbs_prbs_if.prbs   prbs
);
   logic [8:0] lfsr_reg;

   // Nine-bit shift, taps at x^9 and x^5; reseeded per calibration
   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         lfsr_reg <= PRBS_SEED;
      end else if (prbs.init) begin
         lfsr_reg <= PRBS_SEED;
      end else if (prbs.step) begin
         lfsr_reg <= {lfsr_reg[0] ^ lfsr_reg[5], lfsr_reg[8:1]};
      end
   end

   // Low bit leaves first
   assign prbs.bit_out = lfsr_reg[0];
endmodule : hbs_prbs9

/* File: hbs_edge_sync.sv */
`timescale 1ns/100ps
module hbs_edge_sync (
   input  wire logic ref_clk_i,
   input  wire logic rst_i,
   input  wire logic async_i,
   output logic      rise_o
);
   logic meta_reg;
   logic sync_reg;
   logic last_reg;

   // Two flops before use; the second and a delayed copy of it in a third flop form the edge
   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         meta_reg <= 1'b0;
         sync_reg <= 1'b0;
         last_reg <= 1'b0;
      end else begin
         meta_reg <= async_i;
         sync_reg <= meta_reg;
         last_reg <= sync_reg;
      end
   end

   assign rise_o = sync_reg & ~last_reg;
endmodule : hbs_edge_sync

/* File: hbs_inserter.sv */
// The Avalon-MM register port and the register addresses were decided locally.
`timescale 1ns/100ps
// How it works
// - Alternate calibration is forced at 2.5 Gbps and above, also when the rate rises into that range.
// - At those rates it follows directly after the skew calibration.
// - It is HS-0, then sync word, then PRBS9 payload.
// - Sync word is 11110000 lasting 8 UI.
// - Generator reseeded before each PRBS payload; payload sent low bit first.
// - Payload length programmable, accepted up to 100 microseconds.
// - Below 2.5 Gbps the calibration is optional by a control bit.
// - Order: 128 stops, 16 stops, LP-10 entry, calibration, 128 stops.
// - Preamble only above 2.5 Gbps with enable set; else enable ignored.
// - Burst starts with HS-0 then leader 00011101, then data.
// - Enabled preamble is in every burst, right after the HS-0.
// - Preamble repeats 101010 for 32 to 512 UI.
// - Preamble length is steps times 32 UI; steps reset to 1.
// - After preamble, 8 UI of HS-1 before the leader.
// - Two bursts may be joined by HS idle, no LP in between.
// - Idle: clock runs trail time, holds HS-0, runs lead time.
// - The three idle times are programmable with reset defaults.
// - Burst before idle ends without stop state.
// - Idle loop: 128 stops, stop, payload, idle, payload, stop, repeat.
// - The joined pair of payloads is framed by one stop before and after.
module hbs_inserter
   import hbs_pkg::*;
(
   input  wire logic        ref_clk_i,
   input  wire logic        rst_i,
   input  wire logic        link_clk_i,
   input  wire logic [5:0]  avs_address_i,
   input  wire logic        avs_read_i,
   input  wire logic        avs_write_i,
   input  wire logic [31:0] avs_writedata_i,
   output logic [31:0]      avs_readdata_o,
   output logic             avs_waitrequest_o,
   output logic [1:0]       lane_lp_o,
   output logic             lane_hs_en_o,
   output logic             lane_hs_bit_o,
   output logic             clk_run_o,
   output logic             busy_o
);
   hbs_prbs_if prbs_bus ();

   logic        ui_tick;
   logic        ack_reg;
   logic        acc;
   logic        wr_en;
   logic        go_cal_reg;
   logic        run_idle_reg;
   logic        cal_low_reg;
   logic        pre_en_reg;
   logic        cal_pend_reg;
   logic [15:0] rate_reg;
   logic [23:0] cal_len_reg;
   logic [23:0] skew_len_reg;
   logic [4:0]  pre_steps_reg;
   logic [23:0] idl_trail_reg;
   logic [23:0] idl_zero_reg;
   logic [23:0] idl_lead_reg;
   logic [23:0] pay_len_reg;
   logic [7:0]  pay_word_reg;
   logic [23:0] cal_max;
   logic        alt_req;
   logic        pre_on;
   logic        second_reg;
   hbs_state_e  state_reg;
   hbs_state_e  state_next;
   logic [23:0] cnt_reg;
   logic [2:0]  idx_reg;
   logic        bit_next;
   logic [1:0]  lp_next;
   logic        hs_next;

   // True when the programmed rate is at or above the threshold
   function automatic logic rate_at_or_above(input logic [15:0] r);
      return r >= RATE_THRESH_MBPS;
   endfunction : rate_at_or_above

   // Clamps a written step count into the legal span
   function automatic logic [4:0] clamp_steps(input logic [31:0] d);
      if (d[4:0] == 5'h00) begin
         return RST_PRE_STEPS;
      end
      if (d[31:5] != 27'h0 || d[4:0] > MAX_PRE_STEPS) begin
         return MAX_PRE_STEPS;
      end
      return d[4:0];
   endfunction : clamp_steps

   hbs_edge_sync u_link_sync (
      .ref_clk_i (ref_clk_i),
      .rst_i     (rst_i),
      .async_i   (link_clk_i),
      .rise_o    (ui_tick)
   );

   hbs_prbs9 u_prbs (
      .ref_clk_i (ref_clk_i),
      .rst_i     (rst_i),
      .prbs      (prbs_bus.prbs)
   );

   // One wait cycle per access keeps read data registered
   assign acc               = (avs_read_i | avs_write_i) & ~ack_reg;
   assign avs_waitrequest_o = acc;
   assign wr_en             = avs_write_i & ack_reg; // Lands where waitrequest is low

   // Payload ceiling: rate in Mbit/s times microseconds gives UI
   assign cal_max = 24'(rate_reg * CAL_MAX_US);
   assign alt_req = rate_at_or_above(rate_reg) | cal_low_reg;
   assign pre_on  = (rate_reg > RATE_THRESH_MBPS) & pre_en_reg;

   // Bus acknowledge and read data
   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         ack_reg        <= 1'b0;
         avs_readdata_o <= 32'h0000_0000;
      end else begin
         ack_reg <= acc;
         if (avs_read_i & acc) begin
            unique case (avs_address_i)
               OFS_CTRL:      avs_readdata_o <= {28'h000_0000, pre_en_reg, cal_low_reg,
                                                 run_idle_reg, go_cal_reg};
               OFS_RATE:      avs_readdata_o <= {16'h0000, rate_reg};
               OFS_CAL_LEN:   avs_readdata_o <= {8'h00, cal_len_reg};
               OFS_SKEW_LEN:  avs_readdata_o <= {8'h00, skew_len_reg};
               OFS_PRE_STEPS: avs_readdata_o <= {27'h000_0000, pre_steps_reg};
               OFS_IDL_TRAIL: avs_readdata_o <= {8'h00, idl_trail_reg};
               OFS_IDL_ZERO:  avs_readdata_o <= {8'h00, idl_zero_reg};
               OFS_IDL_LEAD:  avs_readdata_o <= {8'h00, idl_lead_reg};
               OFS_PAY_LEN:   avs_readdata_o <= {8'h00, pay_len_reg};
               OFS_PAY_WORD:  avs_readdata_o <= {24'h00_0000, pay_word_reg};
               OFS_STATUS:    avs_readdata_o <= {24'h00_0000, cal_pend_reg, second_reg,
                                                 busy_o, state_reg};
               default:       avs_readdata_o <= 32'h0000_0000;
            endcase
         end
      end
   end

   // Configuration registers; writes to unmapped offsets are dropped
   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         run_idle_reg  <= 1'b0;
         cal_low_reg   <= 1'b0;
         pre_en_reg    <= 1'b0;
         rate_reg      <= RST_RATE;
         cal_len_reg   <= RST_CAL_LEN;
         skew_len_reg  <= RST_SKEW_LEN;
         pre_steps_reg <= RST_PRE_STEPS;
         idl_trail_reg <= RST_IDL_TRAIL;
         idl_zero_reg  <= RST_IDL_ZERO;
         idl_lead_reg  <= RST_IDL_LEAD;
         pay_len_reg   <= RST_PAY_LEN;
         pay_word_reg  <= RST_PAY_WORD;
      end else if (wr_en) begin
         unique case (avs_address_i)
            OFS_CTRL: begin
               run_idle_reg <= avs_writedata_i[CTRL_RUN_IDLE];
               cal_low_reg  <= avs_writedata_i[CTRL_CAL_LOW];
               pre_en_reg   <= avs_writedata_i[CTRL_PRE_EN];
            end
            OFS_RATE:      rate_reg <= avs_writedata_i[15:0];
            OFS_CAL_LEN:   cal_len_reg <= (avs_writedata_i > {8'h00, cal_max}) ?
                                          cal_max : avs_writedata_i[23:0];
            OFS_SKEW_LEN:  skew_len_reg <= avs_writedata_i[23:0];
            OFS_PRE_STEPS: pre_steps_reg <= clamp_steps(avs_writedata_i);
            OFS_IDL_TRAIL: idl_trail_reg <= avs_writedata_i[23:0];
            OFS_IDL_ZERO:  idl_zero_reg <= avs_writedata_i[23:0];
            OFS_IDL_LEAD:  idl_lead_reg <= avs_writedata_i[23:0];
            OFS_PAY_LEN:   pay_len_reg <= avs_writedata_i[23:0];
            OFS_PAY_WORD:  pay_word_reg <= avs_writedata_i[7:0];
            default: ;
         endcase
      end
   end

   // Calibration requests: software kick or a rate moved into the fast range;
   // a request that lands while one is taken is held, not lost
   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         go_cal_reg   <= 1'b0;
         cal_pend_reg <= 1'b0;
      end else begin
         go_cal_reg <= wr_en && avs_address_i == OFS_CTRL && avs_writedata_i[CTRL_GO_CAL];
         if (go_cal_reg || (wr_en && avs_address_i == OFS_RATE &&
             rate_at_or_above(avs_writedata_i[15:0]) && !rate_at_or_above(rate_reg))) begin
            cal_pend_reg <= 1'b1;
         end else if (ui_tick && state_reg == ST_IDLE) begin
            cal_pend_reg <= 1'b0;
         end
      end
   end

   // Length of each line state in UI
   function automatic logic [23:0] state_len(input hbs_state_e s);
      unique case (s)
         ST_INIT, ST_POSTCAL:       return LEN_STOP_LONG;
         ST_PRECAL:                 return LEN_STOP_PRE;
         ST_CAL_ENTRY, ST_B_ENTRY:  return LEN_ENTRY;
         ST_SKEW:                   return skew_len_reg;
         ST_ALT_HS0, ST_B_HS0:      return LEN_HS0;
         ST_ALT_SYNC, ST_B_EXT:     return LEN_BYTE;
         ST_B_LEAD:                 return LEN_BYTE;
         ST_ALT_PRBS:               return cal_len_reg;
         ST_B_PRE:                  return 24'(pre_steps_reg * LEN_PRE_STEP);
         ST_B_DATA:                 return pay_len_reg;
         ST_I_TRAIL:                return idl_trail_reg;
         ST_I_ZERO:                 return idl_zero_reg;
         ST_I_LEAD:                 return idl_lead_reg;
         ST_B_STOP, ST_B_END:       return LEN_STOP_ONE;
         ST_IDLE:                   return LEN_STOP_ONE;
      endcase
   endfunction : state_len

   // Successor of each line state
   always_comb begin
      state_next = state_reg;
      unique case (state_reg)
         ST_IDLE: begin
            if (cal_pend_reg) begin
               state_next = ST_INIT;
            end else if (run_idle_reg) begin
               state_next = ST_INIT;
            end
         end
         ST_INIT:      state_next = second_reg ? ST_B_STOP : ST_PRECAL;
         ST_PRECAL:    state_next = ST_CAL_ENTRY;
         ST_CAL_ENTRY: state_next = ST_SKEW;
         ST_SKEW:      state_next = alt_req ? ST_ALT_HS0 : ST_POSTCAL;
         ST_ALT_HS0:   state_next = ST_ALT_SYNC;
         ST_ALT_SYNC:  state_next = ST_ALT_PRBS;
         ST_ALT_PRBS:  state_next = ST_POSTCAL;
         ST_POSTCAL:   state_next = ST_IDLE;
         ST_B_STOP:    state_next = ST_B_ENTRY;
         ST_B_ENTRY:   state_next = ST_B_HS0;
         ST_B_HS0:     state_next = pre_on ? ST_B_PRE : ST_B_LEAD;
         ST_B_PRE:     state_next = ST_B_EXT;
         ST_B_EXT:     state_next = ST_B_LEAD;
         ST_B_LEAD:    state_next = ST_B_DATA;
         ST_B_DATA:    state_next = second_reg ? ST_B_END : ST_I_TRAIL;
         ST_I_TRAIL:   state_next = ST_I_ZERO;
         ST_I_ZERO:    state_next = ST_I_LEAD;
         ST_I_LEAD:    state_next = ST_B_HS0;
         ST_B_END:     state_next = run_idle_reg ? ST_INIT : ST_IDLE;
         default:      state_next = ST_IDLE;
      endcase
   end

   // Sequencer advances one UI per sampled link clock edge
   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         state_reg  <= ST_IDLE;
         cnt_reg    <= LEN_STOP_ONE;
         idx_reg    <= 3'h0;
         second_reg <= 1'b0;
      end else if (ui_tick) begin
         if (state_reg == ST_IDLE || cnt_reg <= LEN_STOP_ONE) begin
            state_reg <= state_next;
            cnt_reg   <= state_len(state_next);
            idx_reg   <= 3'h0;
            if (state_reg == ST_IDLE) begin
               second_reg <= !cal_pend_reg; // Idle loop, not calibration
            end else if (state_reg == ST_I_LEAD) begin
               second_reg <= 1'b1;
            end else if (state_reg == ST_INIT && second_reg) begin
               second_reg <= 1'b0; // Loop restarts with first payload
            end
         end else begin
            cnt_reg <= cnt_reg - LEN_STOP_ONE;
            idx_reg <= idx_reg + 3'h1;
         end
      end
   end

   // Reseed during the sync word, step once per payload UI
   assign prbs_bus.init = ui_tick && state_reg == ST_ALT_SYNC;
   assign prbs_bus.step = ui_tick && state_reg == ST_ALT_PRBS;

   // Line levels chosen from the current state and bit index
   always_comb begin
      lp_next  = LP_STOP;
      hs_next  = 1'b1;
      bit_next = 1'b0;
      unique case (state_reg)
         ST_IDLE, ST_INIT, ST_PRECAL, ST_POSTCAL, ST_B_STOP, ST_B_END: begin
            hs_next = 1'b0;
         end
         ST_CAL_ENTRY, ST_B_ENTRY: begin
            hs_next = 1'b0;
            lp_next = (idx_reg == 3'h0) ? LP_10 : LP_00;
         end
         ST_SKEW:     bit_next = idx_reg[0];
         ST_ALT_HS0:  bit_next = 1'b0;
         ST_ALT_SYNC: bit_next = ALT_SYNC_WORD[3'h7 - idx_reg];
         ST_ALT_PRBS: bit_next = prbs_bus.bit_out;
         ST_B_HS0:    bit_next = 1'b0;
         ST_B_PRE:    bit_next = ~idx_reg[0];
         ST_B_EXT:    bit_next = 1'b1;
         ST_B_LEAD:   bit_next = LEADER_WORD[3'h7 - idx_reg];
         ST_B_DATA:   bit_next = pay_word_reg[idx_reg];
         ST_I_TRAIL, ST_I_ZERO, ST_I_LEAD: bit_next = 1'b0;
         default:     hs_next = 1'b0;
      endcase
      if (!hs_next) begin
         bit_next = 1'b0;
      end
   end

   // Line outputs held in flops, refreshed on each UI
   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         lane_lp_o     <= LP_STOP;
         lane_hs_en_o  <= 1'b0;
         lane_hs_bit_o <= 1'b0;
         clk_run_o     <= 1'b0;
         busy_o        <= 1'b0;
      end else if (ui_tick) begin
         lane_lp_o     <= hs_next ? LP_00 : lp_next;
         lane_hs_en_o  <= hs_next;
         lane_hs_bit_o <= bit_next;
         clk_run_o     <= hs_next && state_reg != ST_I_ZERO;
         busy_o        <= state_reg != ST_IDLE;
      end
   end
endmodule : hbs_inserter

/* File: hbs_inserter_checker.sv */
`timescale 1ns/100ps
// Pin-level watch on the inserter: bus handshake and lane state order
module hbs_inserter_checker
   import hbs_pkg::*;
(
   input wire logic       ref_clk_i,
   input wire logic       rst_i,
   input wire logic       avs_read_i,
   input wire logic       avs_write_i,
   input wire logic       avs_waitrequest_o,
   input wire logic [1:0] lane_lp_o,
   input wire logic       lane_hs_en_o,
   input wire logic       lane_hs_bit_o,
   input wire logic       clk_run_o,
   input wire logic       busy_o
);
   default clocking @(posedge ref_clk_i); endclocking
   default disable iff (rst_i);

   // One wait cycle per access, never more
   wait_one_a:
   assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o)
      else $error("waitrequest held past one cycle");
   lp_in_hs_a:
   assert property (lane_hs_en_o |-> lane_lp_o == LP_00) else $error("lp level left during hs");
   bit_quiet_a:
   assert property (!lane_hs_en_o |-> !lane_hs_bit_o) else $error("hs bit outside hs");
   // Entry must walk stop, LP-10, LP-00
   entry_stop_a:
   assert property ($changed(lane_lp_o) && lane_lp_o == LP_10 |-> $past(lane_lp_o) == LP_STOP)
      else $error("LP-10 not entered from stop");
   entry_lp00_a:
   assert property (!lane_hs_en_o && lane_lp_o == LP_00 && $changed(lane_lp_o)
                    |-> $past(lane_lp_o) == LP_10) else $error("LP-00 not after LP-10");
   hs_start_zero_a:
   assert property ($rose(lane_hs_en_o) |-> !lane_hs_bit_o && $past(lane_lp_o) == LP_00)
      else $error("hs not opened with zero");
   hs_exit_stop_a:
   assert property ($fell(lane_hs_en_o) |-> lane_lp_o == LP_STOP) else $error("hs exit not stop");
   clk_zero_data_a:
   assert property (lane_hs_en_o && !clk_run_o |-> !lane_hs_bit_o)
      else $error("data lane not zero in clock-zero");
   clk_in_hs_a:
   assert property (clk_run_o |-> lane_hs_en_o && busy_o) else $error("clock lane runs outside hs");
   // A UI is eight system cycles, so a bit never changes twice in six
   ui_hold_a:
   assert property ($changed(lane_hs_bit_o) |=> $stable(lane_hs_bit_o) [*5])
      else $error("hs bit shorter than one UI");

   cover property ($rose(lane_hs_en_o));
   cover property ($fell(clk_run_o) && lane_hs_en_o);
   cover property (avs_write_i && !avs_waitrequest_o);
endmodule : hbs_inserter_checker

/* File: hbs_rx_model.sv */
`timescale 1ns/100ps
// Receiver stand-in: makes the bit clock and logs one lane state per UI
module hbs_rx_model
   import hbs_pkg::*;
(
   output logic            link_clk_o,
   input  wire logic [1:0] lane_lp_i,
   input  wire logic       lane_hs_en_i,
   input  wire logic       lane_hs_bit_i,
   input  wire logic       clk_run_i
);
   logic [4:0] trace[$];
   // Free-running bit clock, 200 ns; stop states are counted in UI too
   initial begin
      link_clk_o = 1'b0;
      forever #100 link_clk_o = ~link_clk_o;
   end
   // Mid-UI sample, well clear of the three-cycle output lag
   always @(negedge link_clk_o) trace.push_back({lane_lp_i, lane_hs_en_i, lane_hs_bit_i, clk_run_i});
endmodule : hbs_rx_model

/* File: hs_burst_sequence_inserter_tb.sv */
`timescale 1ns/100ps
module hs_burst_sequence_inserter_tb
   import hbs_pkg::*;
;
   localparam logic [4:0] HS0 = {LP_00, 3'b101};
   localparam logic [4:0] STP = {LP_STOP, 3'b000};
   logic        ref_clk_i = 1'b0;
   logic        rst_i = 1'b1;
   logic        link_clk;
   logic [5:0]  avs_address_i = '0;
   logic        avs_read_i = 1'b0;
   logic        avs_write_i = 1'b0;
   logic [31:0] avs_writedata_i = '0;
   logic [31:0] avs_readdata_o, rd_q;
   logic        avs_waitrequest_o, lane_hs_en_o, lane_hs_bit_o, clk_run_o, busy_o;
   logic [1:0]  lane_lp_o;
   logic [4:0]  exp_q[$];
   int          num_errors = 0, checks_done = 0, cycles = 0;

   hbs_rx_model rx (.link_clk_o(link_clk), .lane_lp_i(lane_lp_o), .lane_hs_en_i(lane_hs_en_o),
                    .lane_hs_bit_i(lane_hs_bit_o), .clk_run_i(clk_run_o));
   hbs_inserter dut (.ref_clk_i, .rst_i, .link_clk_i(link_clk), .avs_address_i, .avs_read_i,
                     .avs_write_i, .avs_writedata_i, .avs_readdata_o, .avs_waitrequest_o,
                     .lane_lp_o, .lane_hs_en_o, .lane_hs_bit_o, .clk_run_o, .busy_o);

   always #12.5 ref_clk_i = ~ref_clk_i;
   // Hang guard, nearly three times the expected run
   always @(posedge ref_clk_i) begin
      cycles++;
      if (cycles == 40000) begin
         num_errors++;
         report_and_stop();
      end
   end

   task report_and_stop();
      $display("checks %0d errors %0d", checks_done, num_errors);
      if (num_errors == 0 && checks_done > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : report_and_stop

   task chk(input logic [31:0] got, input logic [31:0] want);
      checks_done++;
      if (got !== want) begin
         num_errors++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, want);
      end
   endtask : chk

   // Request stands until the edge that samples waitrequest low; hangs end by timeout
   task bus(input logic w, input logic [5:0] a, input logic [31:0] d);
      @(posedge ref_clk_i);
      avs_address_i <= a;
      avs_writedata_i <= d;
      avs_read_i <= !w;
      avs_write_i <= w;
      do begin
         @(posedge ref_clk_i);
      end while (avs_waitrequest_o !== 1'b0);
      rd_q = avs_readdata_o;
      avs_read_i <= 1'b0;
      avs_write_i <= 1'b0;
   endtask : bus

   task rd_chk(input logic [5:0] a, input logic [31:0] want);
      bus(1'b0, a, '0);
      chk(rd_q, want);
   endtask : rd_chk

   task wait_busy(input logic lvl);
      int n;
      n = 0;
      while (busy_o !== lvl && n < 9000) begin
         @(negedge ref_clk_i);
         n++;
      end
      chk(busy_o, lvl);
   endtask : wait_busy

   // Optional kick, then control is rewritten once the sequencer is running
   task run_seq(input logic [31:0] go, input logic [31:0] after);
      rx.trace.delete();
      if (go != 0) bus(1'b1, OFS_CTRL, go);
      wait_busy(1'b1);
      bus(1'b1, OFS_CTRL, after);
      wait_busy(1'b0);
   endtask : run_seq

   task put(input int n, input logic [4:0] e);
      repeat (n) exp_q.push_back(e);
   endtask : put

   task put_bits(input logic [7:0] v, input int n, input bit lsb);
      for (int i = 0; i < n; i++) exp_q.push_back({LP_00, 1'b1, v[lsb ? i : n - 1 - i], 1'b1});
   endtask : put_bits

   // Entry, four skew UIs, optional alternate calibration, then stop
   task put_cal(input bit alt);
      logic [8:0] s;
      s = PRBS_SEED;
      put(1, {LP_10, 3'b000});
      put(1, 5'b00000);
      repeat (2) put_bits(8'h01, 2, 1'b0);
      if (alt) begin
         put(8, HS0);
         put_bits(ALT_SYNC_WORD, 8, 1'b0);
         repeat (20) begin
            put_bits({7'b0, s[0]}, 1, 1'b0);
            s = {s[0] ^ s[5], s[8:1]};
         end
      end
      put(128, STP); // Full post-calibration stop run
   endtask : put_cal

   task put_burst(input int steps);
      put(8, HS0);
      repeat (steps * 16) put_bits(8'h02, 2, 1'b0);
      if (steps > 0) put(8, {LP_00, 3'b111});
      put_bits(LEADER_WORD, 8, 1'b0);
      repeat (2) put_bits(RST_PAY_WORD, 8, 1'b1);
   endtask : put_burst

   // Lines up the log at the first LP-10; clock lane is ignored outside hs
   task cmp_trace();
      int k;
      k = 0;
      while (k < rx.trace.size() && rx.trace[k][4:3] !== LP_10) k++;
      foreach (exp_q[j]) chk({rx.trace[k + j][4:1], rx.trace[k + j][0] & exp_q[j][2]}, exp_q[j]);
      exp_q.delete();
   endtask : cmp_trace

   task t_regs();
      rd_chk(OFS_RATE, 32'h0000_03E8);
      rd_chk(OFS_PRE_STEPS, 32'h0000_0001);
      for (int i = 0; i < 3; i++) rd_chk(OFS_IDL_TRAIL + 6'(4 * i), 32'h0000_0040);
      rd_chk(6'h2C, 32'h0000_0000);
      bus(1'b1, OFS_PRE_STEPS, 32'h0000_0000);
      rd_chk(OFS_PRE_STEPS, 32'h0000_0001);
      bus(1'b1, OFS_PRE_STEPS, 32'h0000_001F);
      rd_chk(OFS_PRE_STEPS, 32'h0000_0010);
      bus(1'b1, OFS_CAL_LEN, 32'h00FF_FFFF);
      rd_chk(OFS_CAL_LEN, 32'h0001_86A0);
      for (int i = 0; i < 3; i++) bus(1'b1, OFS_IDL_TRAIL + 6'(4 * i), 32'(3 + i));
      rd_chk(OFS_IDL_LEAD, 32'h0000_0005);
      bus(1'b1, OFS_SKEW_LEN, 32'h0000_0004);
      bus(1'b1, OFS_CAL_LEN, 32'h0000_0014);
      bus(1'b1, OFS_PAY_LEN, 32'h0000_0010);
      $display("test regs done, errors %0d", num_errors);
   endtask : t_regs

   task t_cal();
      run_seq(32'h0000_0001, 32'h0000_0000);
      put_cal(1'b0);
      cmp_trace();
      run_seq(32'h0000_0005, 32'h0000_0004);
      put_cal(1'b1);
      cmp_trace();
      bus(1'b1, OFS_RATE, 32'h0000_09C4);
      run_seq(32'h0000_0000, 32'h0000_0000);
      put_cal(1'b1);
      cmp_trace();
      run_seq(32'h0000_0001, 32'h0000_0000);
      put_cal(1'b1);
      cmp_trace();
      $display("test cal done, errors %0d", num_errors);
   endtask : t_cal

   // Two bursts joined by hs idle; preamble only when rate is over threshold
   task t_idle(input logic [31:0] rate, input int steps, input bit pre);
      bus(1'b1, OFS_RATE, rate);
      bus(1'b1, OFS_PRE_STEPS, 32'(steps));
      run_seq(32'h0000_000A, 32'h0000_0008); // Preamble enable kept, loop ends
      put(1, {LP_10, 3'b000});
      put(1, 5'b00000);
      put_burst(pre ? steps : 0);
      put(3, HS0);
      put(4, {LP_00, 3'b100});
      put(5, HS0);
      put_burst(pre ? steps : 0);
      put(1, STP);
      cmp_trace();
      $display("test idle done, errors %0d", num_errors);
   endtask : t_idle

   initial begin
      repeat (12) @(posedge ref_clk_i);
      rst_i <= 1'b0;
      t_regs();
      t_cal();
      t_idle(32'h0000_09C4, 1, 1'b0);
      t_idle(32'h0000_0BB8, 2, 1'b1);
      report_and_stop();
   end
endmodule : hs_burst_sequence_inserter_tb

bind hbs_inserter hbs_inserter_checker chk (.ref_clk_i, .rst_i, .avs_read_i, .avs_write_i,
   .avs_waitrequest_o, .lane_lp_o, .lane_hs_en_o, .lane_hs_bit_o, .clk_run_o, .busy_o);
